//--- cbcg_pkg.sv
//======================================================================
// Behaviour
// - prescaler codes 10 and 11 divide by 3 and 4
// - bit divider codes select 1 to 3.5 ratios
// - bit rate is clock/prescale/divider/64
// - separate encode/decode dividers share one prescaler
// - filter clock has own prescaler and divider
// - general reset powers down all but oscillator
// - mode code selects ADM, PCM, mu-law, A-law
// - buffered ADM moves one byte per eight bits
// - bit clocks internal or both from receive clock
// - running recovery loop makes receive input analog
// - loop off may bypass and power down filter
// - burst mode keeps receive input plain digital
// - prescaler codes 00 and 01 divide by 1, 2
package cbcg_pkg;
    typedef logic [2:0] cbcg_mode_t;

    // serial control bus addresses
    localparam logic [7:0] ADDR_GEN_RESET = 8'h01;
    localparam logic [7:0] ADDR_MODE      = 8'h70;
    localparam logic [7:0] ADDR_CLKDIV    = 8'h72;
    localparam logic [7:0] ADDR_CLKSRC    = 8'h73;
    localparam logic [7:0] ADDR_STATUS    = 8'h7F;

    // reset values
    localparam logic [15:0] CLKDIV_RESET = 16'h0000;
    localparam logic [15:0] CLKSRC_RESET = 16'h0000;
    localparam cbcg_mode_t  MODE_RESET   = 3'h0;

    // clock divider control fields
    localparam int PRE_LSB   = 6;
    localparam int ENC_LSB   = 3;
    localparam int DEC_LSB   = 0;
    localparam int FPRE_LSB  = 8;
    localparam int FMAIN_LSB = 10;

    // clock source control bits
    localparam int SRC_PLL_BIT    = 7;
    localparam int SRC_RXCLK_BIT  = 5;
    localparam int SRC_BYPASS_BIT = 3;
    localparam int SRC_ANALOG_BIT = 1;

    // codec modes
    localparam cbcg_mode_t MODE_ADM_SERIAL = 3'h0;
    localparam cbcg_mode_t MODE_ADM_BUF    = 3'h1;
    localparam cbcg_mode_t MODE_PCM_LIN    = 3'h2;
    localparam cbcg_mode_t MODE_MU_LAW     = 3'h3;
    localparam cbcg_mode_t MODE_A_LAW      = 3'h4;

    // divider constants, bit ratios held in eighths
    localparam logic [5:0] FRAC_ONE   = 6'h08;
    localparam logic [4:0] FIX_LAST   = 5'h1F;
    localparam logic [4:0] PLL_ALIGN  = 5'h10;
    localparam logic [4:0] FMAIN_UNIT = 5'h04;
    localparam logic [2:0] BYTE_LAST  = 3'h7;
    localparam logic [5:0] BIT_DIV_X8 [0:7] = '{6'h08, 6'h10, 6'h12, 6'h15,
                                                6'h18, 6'h19, 6'h1B, 6'h1C};

    // control bus frame states
    typedef enum logic [2:0] {
        S_ADDR = 3'b001,
        S_DATA = 3'b010,
        S_DONE = 3'b100
    } cbcg_bus_e;

    // synchroniser lanes
    localparam int LN_SCLK = 0;
    localparam int LN_CSN  = 1;
    localparam int LN_CMD  = 2;
    localparam int LN_RXC  = 3;
    localparam int LN_RXD  = 4;
endpackage

//--- cbcg_core.sv
`timescale 1ns/1ps
`default_nettype none
module cbcg_core (
    input  wire logic              mclk_in,
    input  wire logic              arst_n_in,
    input  wire logic              cbus_clk_in,
    input  wire logic              cbus_csn_in,
    input  wire logic              cbus_cmd_in,
    output var  logic              cbus_reply_out,
    input  wire logic              rx_bit_clk_in,
    input  wire logic              rx_data_in,
    output var  logic              enc_bit_clk_out,
    output var  logic              dec_bit_clk_out,
    output var  logic              switched_cap_filter_clock_out,
    output var  logic              byte_strobe_out,
    output var  cbcg_pkg::cbcg_mode_t codec_mode_out,
    output var  logic              powered_down_out,
    output var  logic              rx_analog_out,
    output var  logic              data_filter_en_out
);
    import cbcg_pkg::*;

    //==================================================================
    // pin synchronisers
    logic [4:0] pins;
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic [4:0] sync3_q;
    assign pins = {rx_data_in, rx_bit_clk_in, cbus_cmd_in, cbus_csn_in, cbus_clk_in};

    // sync3 only feeds edge detection, never the first stage
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync1_q <= 5'h02; // select idles high, no false frame after reset
            sync2_q <= 5'h02;
            sync3_q <= 5'h02;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    //==================================================================
    // control bus slave and registers
    cbcg_bus_e  state_q, state_d;
    logic [7:0] shift_q, shift_d, addr_q, addr_d, hi_q, hi_d, reply_q, reply_d;
    logic [2:0] bitcnt_q, bitcnt_d;
    logic       hi_got_q, hi_got_d, pd_q, pd_d;
    logic [15:0] clkdiv_q, clkdiv_d, clksrc_q, clksrc_d;
    cbcg_mode_t mode_q, mode_d;
    logic       sclk_rise, byte_done, burst, pll_active, src_rx, analog_d, filt_en_d;
    logic [7:0] byte_w, status_w;

    assign sclk_rise = sync2_q[LN_SCLK] & ~sync3_q[LN_SCLK];
    assign byte_w    = {shift_q[6:0], sync2_q[LN_CMD]};
    assign byte_done = ~sync2_q[LN_CSN] & sclk_rise & (bitcnt_q == BYTE_LAST);
    // burst framing owns the receive pin, so it overrides the loop
    assign burst      = (mode_q != MODE_ADM_SERIAL);
    assign pll_active = clksrc_q[SRC_PLL_BIT] & ~burst;
    assign src_rx     = clksrc_q[SRC_RXCLK_BIT] & ~clksrc_q[SRC_BYPASS_BIT] & ~pll_active;
    assign analog_d   = ~burst & (pll_active | clksrc_q[SRC_ANALOG_BIT]);
    assign filt_en_d  = analog_d & ~(clksrc_q[SRC_BYPASS_BIT] & ~pll_active);
    assign status_w   = {pd_q, pll_active, src_rx, rx_analog_out, data_filter_en_out, mode_q};

    // byte framing, msb first, first data byte is the high byte
    always_comb begin
        state_d  = state_q;
        shift_d  = shift_q;
        addr_d   = addr_q;
        hi_d     = hi_q;
        reply_d  = reply_q;
        bitcnt_d = bitcnt_q;
        hi_got_d = hi_got_q;
        pd_d     = pd_q;
        clkdiv_d = clkdiv_q;
        clksrc_d = clksrc_q;
        mode_d   = mode_q;
        if (sync2_q[LN_CSN]) begin
            state_d  = S_ADDR;
            bitcnt_d = 3'h0;
            hi_got_d = 1'b0;
        end else if (sclk_rise) begin
            shift_d  = byte_w;
            reply_d  = {reply_q[6:0], 1'b0};
            bitcnt_d = bitcnt_q + 3'h1;
            if (byte_done) begin
                unique case (state_q)
                    S_ADDR: begin
                        addr_d  = byte_w;
                        state_d = S_DATA;
                        if (byte_w == ADDR_GEN_RESET) begin
                            // only the oscillator keeps running
                            clkdiv_d = CLKDIV_RESET;
                            clksrc_d = CLKSRC_RESET;
                            mode_d   = MODE_RESET;
                            pd_d     = 1'b1;
                            state_d  = S_DONE;
                        end else if (byte_w == ADDR_STATUS) begin
                            reply_d = status_w;
                            state_d = S_DONE;
                        end
                    end
                    S_DATA: begin
                        if (addr_q == ADDR_MODE) begin
                            mode_d  = byte_w[2:0];
                            state_d = S_DONE;
                        end else if ((addr_q == ADDR_CLKDIV) || (addr_q == ADDR_CLKSRC)) begin
                            if (!hi_got_q) begin
                                hi_d     = byte_w;
                                hi_got_d = 1'b1;
                            end else begin
                                state_d = S_DONE;
                                if (addr_q == ADDR_CLKDIV) begin
                                    clkdiv_d = {hi_q, byte_w};
                                    pd_d     = 1'b0;
                                end else begin
                                    clksrc_d = {hi_q, byte_w};
                                end
                            end
                        end else begin
                            state_d = S_DONE; // unmapped, data ignored
                        end
                    end
                    S_DONE: begin
                        state_d = S_DONE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q  <= S_ADDR;
            shift_q  <= 8'h00;
            addr_q   <= 8'h00;
            hi_q     <= 8'h00;
            reply_q  <= 8'h00;
            bitcnt_q <= 3'h0;
            hi_got_q <= 1'b0;
            pd_q     <= 1'b1;
            clkdiv_q <= CLKDIV_RESET;
            clksrc_q <= CLKSRC_RESET;
            mode_q   <= MODE_RESET;
        end else begin
            state_q  <= state_d;
            shift_q  <= shift_d;
            addr_q   <= addr_d;
            hi_q     <= hi_d;
            reply_q  <= reply_d;
            bitcnt_q <= bitcnt_d;
            hi_got_q <= hi_got_d;
            pd_q     <= pd_d;
            clkdiv_q <= clkdiv_d;
            clksrc_q <= clksrc_d;
            mode_q   <= mode_d;
        end
    end

    //==================================================================
    // shared bit clock prescaler, divide by code plus one
    logic [1:0] pre_q, pre_d, ps_code;
    logic       pre_tick;
    logic [1:0] bitclk;
    logic       rxd_edge;
    assign ps_code  = clkdiv_q[PRE_LSB +: 2];
    assign pre_tick = ~pd_q & (pre_q == 2'h0);
    assign rxd_edge = sync2_q[LN_RXD] ^ sync3_q[LN_RXD];

    always_comb begin
        pre_d = pd_q ? 2'h0 : (pre_tick ? ps_code : pre_q - 2'h1);
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pre_q <= 2'h0;
        end else begin
            pre_q <= pre_d;
        end
    end

    //==================================================================
    // per-direction fractional divider and fixed divide by 64
    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        logic [5:0] acc_q, acc_d, sum, r8;
        logic [4:0] fix_q, fix_d;
        logic       clk_q, clk_d, tick;
        // channel 0 encodes, channel 1 decodes
        assign r8   = BIT_DIV_X8[clkdiv_q[(ch == 0 ? ENC_LSB : DEC_LSB) +: 3]];
        assign sum  = acc_q + FRAC_ONE;
        assign tick = pre_tick & (sum >= r8);
        assign bitclk[ch] = clk_q;

        // eighths accumulator keeps the long-term ratio exact
        always_comb begin
            acc_d = acc_q;
            fix_d = fix_q;
            clk_d = clk_q;
            if (pre_tick) begin
                acc_d = tick ? sum - r8 : sum;
            end
            if (tick) begin
                fix_d = fix_q + 5'h01;
                clk_d = (fix_q == FIX_LAST) ? ~clk_q : clk_q;
            end
            // recovery loop re-centres the decode phase on data edges
            if ((ch == 1) && pll_active && rxd_edge) begin
                fix_d = PLL_ALIGN;
                acc_d = 6'h00;
            end
            if (src_rx) begin
                clk_d = sync2_q[LN_RXC];
            end
            if (pd_q) begin
                acc_d = 6'h00;
                fix_d = 5'h00;
                clk_d = 1'b0;
            end
        end

        always_ff @(posedge mclk_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
                acc_q <= 6'h00;
                fix_q <= 5'h00;
                clk_q <= 1'b0;
            end else begin
                acc_q <= acc_d;
                fix_q <= fix_d;
                clk_q <= clk_d;
            end
        end
    end
    assign enc_bit_clk_out = bitclk[0];
    assign dec_bit_clk_out = bitclk[1];

    //==================================================================
    // byte strobe, status flags and filter clock
    logic       enc_prev_q, strobe_q, strobe_d, scf_q, scf_d;
    logic [2:0] bcnt_q, bcnt_d;
    logic [1:0] fpre_q, fpre_d;
    logic [4:0] fmain_q, fmain_d, fratio;
    logic       ftick, ana_q, filt_q;
    assign fratio = FMAIN_UNIT * ((clkdiv_q[FMAIN_LSB +: 3] == 3'h0) ? 5'h01
                                  : {2'h0, clkdiv_q[FMAIN_LSB +: 3]});
    assign ftick  = ~pd_q & (fpre_q == 2'h0);

    // filter path runs apart from the bit dividers
    always_comb begin
        bcnt_d   = bcnt_q;
        strobe_d = 1'b0;
        if (mode_q != MODE_ADM_BUF) begin
            bcnt_d = 3'h0;
        end else if (bitclk[0] & ~enc_prev_q) begin
            bcnt_d   = bcnt_q + 3'h1;
            strobe_d = (bcnt_q == BYTE_LAST);
        end
        fpre_d  = pd_q ? 2'h0 : (ftick ? clkdiv_q[FPRE_LSB +: 2] : fpre_q - 2'h1);
        fmain_d = fmain_q;
        if (ftick) begin
            fmain_d = (fmain_q >= fratio - 5'h01) ? 5'h00 : fmain_q + 5'h01;
        end
        scf_d = ~pd_q & (fmain_d < (fratio >> 1));
        if (pd_q) begin
            fmain_d = 5'h00;
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            enc_prev_q <= 1'b0;
            strobe_q   <= 1'b0;
            bcnt_q     <= 3'h0;
            fpre_q     <= 2'h0;
            fmain_q    <= 5'h00;
            scf_q      <= 1'b0;
            ana_q      <= 1'b0;
            filt_q     <= 1'b0;
        end else begin
            enc_prev_q <= bitclk[0];
            strobe_q   <= strobe_d;
            bcnt_q     <= bcnt_d;
            fpre_q     <= fpre_d;
            fmain_q    <= fmain_d;
            scf_q      <= scf_d;
            ana_q      <= analog_d;
            filt_q     <= filt_en_d;
        end
    end
    assign cbus_reply_out                = reply_q[7];
    assign switched_cap_filter_clock_out = scf_q;
    assign byte_strobe_out               = strobe_q;
    assign codec_mode_out                = mode_q;
    assign powered_down_out              = pd_q;
    assign rx_analog_out                 = ana_q;
    assign data_filter_en_out            = filt_q;

    //==================================================================
    // assertions
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);

    property p_pre_div3;
        (pre_tick && ps_code == 2'h2) ##1 (!pd_q && ps_code == 2'h2) [*3] |-> pre_tick;
    endproperty
    a_pre_div3: assert property (p_pre_div3) else $error("prescaler not dividing by three");

    property p_pre_div1;
        (!pd_q && ps_code == 2'h0 && pre_q == 2'h0) |=> (pd_q || pre_tick);
    endproperty
    a_pre_div1: assert property (p_pre_div1) else $error("prescaler not dividing by one");

    property p_ratio_one;
        (pre_tick && clkdiv_q[ENC_LSB +: 3] == 3'h0 && g_ch[0].acc_q == 6'h00) |-> g_ch[0].tick;
    endproperty
    a_ratio_one: assert property (p_ratio_one) else $error("unity bit divider missed a tick");

    property p_fixed64;
        (!src_rx && !$past(src_rx) && !pd_q && $changed(enc_bit_clk_out) && !$past(pd_q))
            |-> $past(g_ch[0].fix_q == FIX_LAST && g_ch[0].tick);
    endproperty
    a_fixed64: assert property (p_fixed64) else $error("bit clock toggled off the 64 boundary");

    property p_pd_quiet;
        pd_q |=> (!switched_cap_filter_clock_out && !enc_bit_clk_out && !dec_bit_clk_out);
    endproperty
    a_pd_quiet: assert property (p_pd_quiet) else $error("clocks running while powered down");

    property p_mode_write;
        (byte_done && state_q == S_DATA && addr_q == ADDR_MODE)
            |=> codec_mode_out == $past(byte_w[2:0]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("codec mode write lost");

    property p_strobe_space;
        byte_strobe_out |=> !byte_strobe_out [*8];
    endproperty
    a_strobe_space: assert property (p_strobe_space) else $error("byte strobes too close");

    property p_rx_clk;
        (src_rx && !pd_q) |=> (enc_bit_clk_out == $past(sync2_q[LN_RXC]))
                              && (dec_bit_clk_out == $past(sync2_q[LN_RXC]));
    endproperty
    a_rx_clk: assert property (p_rx_clk) else $error("bit clocks not following receive clock");

    property p_pll_analog;
        pll_active |=> (rx_analog_out && data_filter_en_out);
    endproperty
    a_pll_analog: assert property (p_pll_analog) else $error("loop running with digital input");

    property p_bypass;
        (!pll_active && clksrc_q[SRC_BYPASS_BIT]) |=> !data_filter_en_out;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypassed data filter still on");

    property p_burst_digital;
        burst |=> !rx_analog_out;
    endproperty
    a_burst_digital: assert property (p_burst_digital) else $error("burst input treated as analog");

    c_strobe:  cover property (byte_strobe_out);
    c_wake:    cover property ($fell(powered_down_out));
    c_scf:     cover property ($rose(switched_cap_filter_clock_out));
    c_realign: cover property (pll_active && rxd_edge && !pd_q);
endmodule
`default_nettype wire

//--- cbcg_host.sv
`timescale 1ns/1ps
`default_nettype none
//==========================================================
// host model driving the serial control bus
module cbcg_host (
    input  wire logic mclk_in,
    output var  logic cbus_clk_out,
    output var  logic cbus_csn_out,
    output var  logic cbus_cmd_out,
    input  wire logic cbus_reply_in
);
    // serial clock idles low and stands still between frames
    initial begin
        cbus_clk_out = 1'b0;
        cbus_csn_out = 1'b1;
        cbus_cmd_out = 1'b0;
    end

    // one byte msb first; 4 mclk half periods clear the 3 mclk minimum
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            @(posedge mclk_in);
            cbus_cmd_out <= tx[i];
            repeat (3) @(posedge mclk_in);
            rx[i] = cbus_reply_in;
            cbus_clk_out <= 1'b1;
            repeat (4) @(posedge mclk_in);
            cbus_clk_out <= 1'b0;
        end
    endtask

    task automatic open_frame();
        @(posedge mclk_in);
        cbus_csn_out <= 1'b0;
        repeat (3) @(posedge mclk_in);
    endtask

    // released command line shows the inverse of its last bit
    task automatic close_frame();
        repeat (4) @(posedge mclk_in);
        cbus_csn_out <= 1'b1;
        cbus_cmd_out <= ~cbus_cmd_out;
        repeat (8) @(posedge mclk_in);
    endtask

    task automatic wr0(input logic [7:0] addr);
        logic [7:0] rx;
        open_frame();
        xfer(addr, rx);
        close_frame();
    endtask

    task automatic wr8(input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] rx;
        open_frame();
        xfer(addr, rx);
        xfer(data, rx);
        close_frame();
    endtask

    // high byte first; divider pairs are the caller's choice
    task automatic wr16(input logic [7:0] addr, input logic [15:0] data);
        logic [7:0] rx;
        open_frame();
        xfer(addr, rx);
        xfer(data[15:8], rx);
        xfer(data[7:0], rx);
        close_frame();
    endtask

    task automatic rd8(input logic [7:0] addr, output logic [7:0] val);
        logic [7:0] rx;
        open_frame();
        xfer(addr, rx);
        xfer(8'h00, val);
        close_frame();
    endtask
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import cbcg_pkg::*;
    logic       mclk_in, arst_n_in, cbus_clk, cbus_csn, cbus_cmd, cbus_reply;
    logic       rx_bit_clk, rx_data, enc_clk, dec_clk, filt_clk, strobe;
    logic       pd, analog, filt_en;
    cbcg_mode_t mode;
    logic [7:0] st;
    int         error_cnt = 0;
    int         samples_checked = 0;
    int         hi;
    //==========================================================
    // rows: clock divider word, then 8-period spans of enc, dec, filter
    logic [15:0] row_cfg [8] = '{16'hE907, 16'h1E4E, 16'hE995, 16'h1EDC,
                                 16'hE923, 16'h1E6A, 16'hE9B1, 16'h1EF8};
    int row_enc [8] = '{512, 2048, 3456, 5376, 1536, 3200, 5184, 7168};
    int row_dec [8] = '{1792, 3456, 4800, 6144, 1344, 2304, 3072, 2048};
    int row_flt [8] = '{128, 672, 128, 672, 128, 672, 128, 672};

    initial begin
        mclk_in = 1'b0;
        forever #2 mclk_in = ~mclk_in;
    end
    // receive bit clock off the mclk grid on purpose
    initial begin
        rx_bit_clk = 1'b0;
        forever #81.3 rx_bit_clk = ~rx_bit_clk;
    end

    cbcg_core cbcg_core_inst (
        .mclk_in(mclk_in), .arst_n_in(arst_n_in), .cbus_clk_in(cbus_clk),
        .cbus_csn_in(cbus_csn), .cbus_cmd_in(cbus_cmd), .cbus_reply_out(cbus_reply),
        .rx_bit_clk_in(rx_bit_clk), .rx_data_in(rx_data), .enc_bit_clk_out(enc_clk),
        .dec_bit_clk_out(dec_clk), .switched_cap_filter_clock_out(filt_clk),
        .byte_strobe_out(strobe), .codec_mode_out(mode), .powered_down_out(pd),
        .rx_analog_out(analog), .data_filter_en_out(filt_en)
    );
    cbcg_host cbcg_host_inst (
        .mclk_in(mclk_in), .cbus_clk_out(cbus_clk), .cbus_csn_out(cbus_csn),
        .cbus_cmd_out(cbus_cmd), .cbus_reply_in(cbus_reply)
    );

    //==========================================================
    // checking helpers
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("BAD %s expected %0h seen %0h", what, exp, got);
            error_cnt++;
        end
    endtask

    function automatic logic pick(input int sel);
        case (sel)
            0: return enc_clk;
            1: return dec_clk;
            2: return filt_clk;
            default: return strobe;
        endcase
    endfunction

    // mclk count over n periods, bounded so a dead clock ends the run
    task automatic meas(input string what, input int sel, input int n, input int exp);
        int  rises;
        int  cyc;
        logic prev;
        logic cur;
        rises = 0;
        cyc = -1;
        prev = 1'b1;
        for (int k = 0; k < 40000 && rises <= n; k++) begin
            @(posedge mclk_in);
            #1;
            cur = pick(sel);
            if (cur === 1'b1 && prev === 1'b0) rises++;
            if (rises > 0) cyc++;
            prev = cur;
        end
        samples_checked++;
        if (rises <= n || cyc > exp + 4 || cyc < exp - 4) begin
            $display("BAD %s expected %0d seen %0d", what, exp, cyc);
            error_cnt++;
            if (rises <= n) report_and_stop();
        end
    endtask

    initial begin
        repeat (100000) @(posedge mclk_in);
        error_cnt++;
        report_and_stop();
    end

    //==========================================================
    // main sequence
    initial begin
        arst_n_in = 1'b0;
        rx_data = 1'b0;
        repeat (5) @(posedge mclk_in);
        arst_n_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        chk("powered_down", 16'h1, pd);
        chk("enc_clk_idle", 16'h0, enc_clk);
        // every prescale and divider code, encode and decode apart
        for (int r = 0; r < 8; r++) begin
            cbcg_host_inst.wr16(ADDR_CLKDIV, row_cfg[r]);
            chk("powered_down", 16'h0, pd);
            fork
                meas("enc_span", 0, 8, row_enc[r]);
                meas("dec_span", 1, 8, row_dec[r]);
                meas("filt_span", 2, 8, row_flt[r]);
            join
        end
        for (int m = 0; m < 5; m++) begin
            cbcg_host_inst.wr8(ADDR_MODE, 8'(m));
            chk("codec_mode", 16'(m), mode);
        end
        // unmapped address leaves the mode alone
        cbcg_host_inst.wr8(8'h75, 8'h01);
        chk("codec_mode", 16'h4, mode);
        cbcg_host_inst.wr16(ADDR_CLKSRC, 16'h00D2);
        chk("rx_analog", 16'h0, analog);
        cbcg_host_inst.wr8(ADDR_MODE, 8'h00);
        repeat (4) begin
            repeat (10) @(posedge mclk_in);
            rx_data <= ~rx_data;
        end
        chk("rx_analog", 16'h1, analog);
        chk("filter_en", 16'h1, filt_en);
        cbcg_host_inst.rd8(ADDR_STATUS, st);
        chk("status", 16'h58, st);
        cbcg_host_inst.wr16(ADDR_CLKSRC, 16'h0078);
        chk("filter_en", 16'h0, filt_en);
        chk("rx_analog", 16'h0, analog);
        // both bit clocks follow the receive bit clock
        cbcg_host_inst.wr16(ADDR_CLKSRC, 16'h0070);
        fork
            meas("enc_rx_span", 0, 8, 325);
            meas("dec_rx_span", 1, 8, 325);
        join
        cbcg_host_inst.wr16(ADDR_CLKSRC, 16'h0078);
        cbcg_host_inst.wr16(ADDR_CLKDIV, 16'h1E00);
        cbcg_host_inst.wr8(ADDR_MODE, 8'h01);
        meas("byte_strobe_span", 3, 1, 512);
        // general reset: clocks stop, device stays down
        cbcg_host_inst.wr0(ADDR_GEN_RESET);
        chk("powered_down", 16'h1, pd);
        hi = 0;
        repeat (200) begin
            @(posedge mclk_in);
            #1;
            if (enc_clk !== 1'b0 || dec_clk !== 1'b0 || filt_clk !== 1'b0) hi++;
        end
        chk("clocks_idle", 16'h0, 16'(hi));
        // mid-run reset must drop a live configuration
        cbcg_host_inst.wr16(ADDR_CLKDIV, 16'hE907);
        cbcg_host_inst.wr8(ADDR_MODE, 8'h03);
        @(posedge mclk_in);
        arst_n_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        arst_n_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        #1;
        chk("reset_mode", 16'h0, mode);
        chk("reset_powered_down", 16'h1, pd);
        chk("reset_enc_clk", 16'h0, enc_clk);
        report_and_stop();
    end
endmodule
`default_nettype wire
